/* hw/opcode_decoder_regs.svh */
`ifndef OPCODE_DECODER_REGS_SVH
`define OPCODE_DECODER_REGS_SVH

// instruction byte values
`define OP_MAKER_SIG 8'h90
`define OP_IDENT 8'h9F
`define OP_LEGACY_SIG 8'hAB
`define OP_PARAMS 8'h5A
`define OP_STAT_CFG_WR 8'h01
`define OP_STAT_CLR 8'h30
`define OP_WR_LATCH_CLR 8'h04
`define OP_CORR_RD 8'h18
`define OP_BANK_LEGACY 8'hB9
`define OP_LEARN_RD 8'h41
`define OP_LEARN_NV 8'h43
`define OP_LEARN_VOL 8'h4A
`define OP_PLAIN_RD 8'h03
`define OP_PLAIN_RD32 8'h13
`define OP_LAT_RD 8'h0B
`define OP_LAT_RD32 8'h0C
`define OP_DDR_RD 8'h0D
`define OP_DDR_RD32 8'h0E
`define OP_TWO_OUT 8'h3B
`define OP_TWO_OUT32 8'h3C
`define OP_FOUR_OUT 8'h6B
`define OP_FOUR_OUT32 8'h6C
`define OP_TWO_IO 8'hBB
`define OP_TWO_IO32 8'hBC
`define OP_FOUR_IO 8'hEB
`define OP_FOUR_IO32 8'hEC
`define OP_DDR_TWO_IO 8'hBD
`define OP_DDR_TWO_IO32 8'hBE
`define OP_DDR_FOUR_IO 8'hED
`define OP_DDR_FOUR_IO32 8'hEE
`define OP_PAGE 8'h02
`define OP_PAGE32 8'h12
`define OP_PAGE4 8'h32
`define OP_PAGE4_ALT 8'h38
`define OP_PAGE4_32 8'h34

// serial clock ceilings in MHz
`define FMAX_50 8'h32
`define FMAX_80 8'h50
`define FMAX_104 8'h68
`define FMAX_133 8'h85

// reset value of the long address enable
`define LONG_ADDR_RESET 1'b0
// address byte counts
`define ADDR_BYTES_3 3'h3
`define ADDR_BYTES_4 3'h4
`define ADDR_BYTES_0 3'h0
// bit count of the last instruction bit in a byte
`define BITS_PER_BYTE 3'h7

`endif

/* hw/opcode_decoder_pkg.sv */
package opcode_decoder_pkg;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_MAKER_SIG = 5'h01,
        OP_IDENT = 5'h02,
        OP_LEGACY_SIG = 5'h03,
        OP_PARAMS = 5'h04,
        OP_STAT_CFG_WR = 5'h05,
        OP_STAT_CLR = 5'h06,
        OP_WR_LATCH_CLR = 5'h07,
        OP_CORR_RD = 5'h08,
        OP_BANK_ACCESS = 5'h09,
        OP_LEARN_RD = 5'h0A,
        OP_LEARN_NV = 5'h0B,
        OP_LEARN_VOL = 5'h0C,
        OP_PLAIN_RD = 5'h0D,
        OP_LAT_RD = 5'h0E,
        OP_DDR_RD = 5'h0F,
        OP_TWO_OUT = 5'h10,
        OP_FOUR_OUT = 5'h11,
        OP_TWO_IO = 5'h12,
        OP_FOUR_IO = 5'h13,
        OP_DDR_TWO_IO = 5'h14,
        OP_DDR_FOUR_IO = 5'h15,
        OP_PAGE_SINGLE = 5'h16,
        OP_PAGE_FOUR = 5'h17
    } op_kind_t;

    // one decoded instruction as handed to the core
    typedef struct packed {
        op_kind_t kind;
        logic [2:0] addr_bytes;
        logic [7:0] fmax_mhz;
        logic [7:0] opcode;
    } decode_t;

    typedef enum logic [1:0] {
        LS_OPCODE = 2'b00,
        LS_BODY = 2'b01,
        LS_IGNORE = 2'b11
    } link_state_t;

endpackage

/* hw/serial_flash_opcode_decoder.sv */
`timescale 1ns/1ps
`include "opcode_decoder_regs.svh"

module serial_flash_opcode_decoder (
    // core clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // serial link, clocked by the host
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    // core side control
    input wire logic long_address_enable,
    // decoded instruction, core domain
    output logic cmd_valid,
    output opcode_decoder_pkg::decode_t cmd_r,
    output logic cmd_ignored_r,
    output logic failure_cleared_r
);

    // link domain: shift first byte on sck rising edge
    opcode_decoder_pkg::link_state_t ls_r;
    logic [2:0] bit_cnt_r;
    logic [6:0] shift_r;
    logic [7:0] op_byte_r;
    logic done_r;

    // the frame ends on cs_n itself, since sck stops outside frames
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            ls_r <= opcode_decoder_pkg::LS_OPCODE;
            bit_cnt_r <= 3'h0;
            shift_r <= 7'h00;
            done_r <= 1'b0;
        end else begin
            unique case (ls_r)
                opcode_decoder_pkg::LS_OPCODE: begin
                    shift_r <= {shift_r[5:0], si};
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                    if (bit_cnt_r == `BITS_PER_BYTE) begin
                        ls_r <= opcode_decoder_pkg::LS_BODY;
                        done_r <= 1'b1;
                    end
                end
                default: begin
                    ls_r <= ls_r;
                end
            endcase
        end
    end

    // byte survives deselect so the core can still collect it
    always_ff @(posedge sck) begin
        if (!cs_n && ls_r == opcode_decoder_pkg::LS_OPCODE
                && bit_cnt_r == `BITS_PER_BYTE) begin
            op_byte_r <= {shift_r, si};
        end
    end

    // done level crossing into the core; a level cleared by deselect
    // starts known, where an unreset toggle would stay unknown for ever
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic tgl_s3_r;
    logic [7:0] byte_s_r;
    logic long_s1_r;
    logic long_s2_r;
    always_ff @(posedge clk) begin
        tgl_s1_r <= done_r;
        tgl_s2_r <= tgl_s1_r;
        tgl_s3_r <= tgl_s2_r;
        long_s1_r <= long_address_enable;
        long_s2_r <= long_s1_r;
    end

    wire new_byte = tgl_s2_r & ~tgl_s3_r;
    // byte held since done rose two edges ago, safe to sample
    always_ff @(posedge clk) begin
        byte_s_r <= op_byte_r;
    end

    // opcode to kind, address length and ceiling
    function automatic opcode_decoder_pkg::decode_t decode_op(
        input logic [7:0] op,
        input logic long_addr
    );
        opcode_decoder_pkg::decode_t d;
        logic [2:0] var_len;
        d = '{kind: opcode_decoder_pkg::OP_NONE,
              addr_bytes: `ADDR_BYTES_0, fmax_mhz: `FMAX_133, opcode: op};
        var_len = long_addr ? `ADDR_BYTES_4 : `ADDR_BYTES_3;
        unique case (op)
            `OP_MAKER_SIG: d.kind = opcode_decoder_pkg::OP_MAKER_SIG;
            `OP_IDENT: d.kind = opcode_decoder_pkg::OP_IDENT;
            `OP_LEGACY_SIG: begin
                d.kind = opcode_decoder_pkg::OP_LEGACY_SIG;
                d.fmax_mhz = `FMAX_50;
            end
            `OP_PARAMS: d.kind = opcode_decoder_pkg::OP_PARAMS;
            `OP_STAT_CFG_WR: d.kind = opcode_decoder_pkg::OP_STAT_CFG_WR;
            `OP_STAT_CLR: d.kind = opcode_decoder_pkg::OP_STAT_CLR;
            `OP_WR_LATCH_CLR: d.kind = opcode_decoder_pkg::OP_WR_LATCH_CLR;
            `OP_CORR_RD: begin
                d.kind = opcode_decoder_pkg::OP_CORR_RD;
                d.addr_bytes = `ADDR_BYTES_4;
            end
            `OP_BANK_LEGACY: d.kind = opcode_decoder_pkg::OP_BANK_ACCESS;
            `OP_LEARN_RD: d.kind = opcode_decoder_pkg::OP_LEARN_RD;
            `OP_LEARN_NV: d.kind = opcode_decoder_pkg::OP_LEARN_NV;
            `OP_LEARN_VOL: d.kind = opcode_decoder_pkg::OP_LEARN_VOL;
            `OP_PLAIN_RD, `OP_PLAIN_RD32: begin
                d.kind = opcode_decoder_pkg::OP_PLAIN_RD;
                d.fmax_mhz = `FMAX_50;
            end
            `OP_LAT_RD, `OP_LAT_RD32:
                d.kind = opcode_decoder_pkg::OP_LAT_RD;
            `OP_DDR_RD, `OP_DDR_RD32: begin
                d.kind = opcode_decoder_pkg::OP_DDR_RD;
                d.fmax_mhz = `FMAX_80;
            end
            `OP_TWO_OUT, `OP_TWO_OUT32: begin
                d.kind = opcode_decoder_pkg::OP_TWO_OUT;
                d.fmax_mhz = `FMAX_104;
            end
            `OP_FOUR_OUT, `OP_FOUR_OUT32: begin
                d.kind = opcode_decoder_pkg::OP_FOUR_OUT;
                d.fmax_mhz = `FMAX_104;
            end
            `OP_TWO_IO, `OP_TWO_IO32: begin
                d.kind = opcode_decoder_pkg::OP_TWO_IO;
                d.fmax_mhz = `FMAX_104;
            end
            `OP_FOUR_IO, `OP_FOUR_IO32: begin
                d.kind = opcode_decoder_pkg::OP_FOUR_IO;
                d.fmax_mhz = `FMAX_104;
            end
            `OP_DDR_TWO_IO, `OP_DDR_TWO_IO32: begin
                d.kind = opcode_decoder_pkg::OP_DDR_TWO_IO;
                d.fmax_mhz = `FMAX_80;
            end
            `OP_DDR_FOUR_IO, `OP_DDR_FOUR_IO32: begin
                d.kind = opcode_decoder_pkg::OP_DDR_FOUR_IO;
                d.fmax_mhz = `FMAX_80;
            end
            `OP_PAGE, `OP_PAGE32:
                d.kind = opcode_decoder_pkg::OP_PAGE_SINGLE;
            `OP_PAGE4, `OP_PAGE4_ALT, `OP_PAGE4_32: begin
                d.kind = opcode_decoder_pkg::OP_PAGE_FOUR;
                d.fmax_mhz = `FMAX_80;
            end
            default: d.fmax_mhz = `FMAX_133;
        endcase
        // array opcodes: the listed long-form opcodes take a fixed four bytes, the rest the per-mode length
        if (d.kind >= opcode_decoder_pkg::OP_PLAIN_RD) begin
            unique case (op)
                `OP_PLAIN_RD32, `OP_LAT_RD32, `OP_DDR_RD32, `OP_TWO_OUT32,
                `OP_FOUR_OUT32, `OP_TWO_IO32, `OP_FOUR_IO32,
                `OP_DDR_TWO_IO32, `OP_DDR_FOUR_IO32, `OP_PAGE32,
                `OP_PAGE4_32:
                    d.addr_bytes = `ADDR_BYTES_4;
                default: d.addr_bytes = var_len;
            endcase
        end
        return d;
    endfunction

    wire opcode_decoder_pkg::decode_t dec_w = decode_op(byte_s_r, long_s2_r);
    wire known_w = dec_w.kind != opcode_decoder_pkg::OP_NONE;

    // handshake pulse comes straight from the valid register
    logic valid_r;
    assign cmd_valid = valid_r;

    // results register once per frame; unknown opcodes only raise a flag
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            valid_r <= 1'b0;
            cmd_r <= '0;
            cmd_ignored_r <= 1'b0;
        end else begin
            valid_r <= new_byte && known_w;
            cmd_ignored_r <= new_byte ? !known_w : cmd_ignored_r;
            if (new_byte && known_w) begin
                cmd_r <= dec_w;
            end
        end
    end

    // recovery tracker: clear then write latch clear restores standby
    logic clr_seen_r;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clr_seen_r <= 1'b0;
            failure_cleared_r <= 1'b0;
        end else if (new_byte && known_w) begin
            clr_seen_r <= dec_w.kind == opcode_decoder_pkg::OP_STAT_CLR;
            failure_cleared_r <= clr_seen_r &&
                dec_w.kind == opcode_decoder_pkg::OP_WR_LATCH_CLR;
        end
    end

    // checks
    plain_read_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
        valid_r && cmd_r.kind == opcode_decoder_pkg::OP_PLAIN_RD
        |-> cmd_r.fmax_mhz == `FMAX_50)
        else $error("plain read ceiling wrong");
    legacy_sig_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
        valid_r && cmd_r.opcode == `OP_LEGACY_SIG
        |-> cmd_r.fmax_mhz == `FMAX_50)
        else $error("legacy signature ceiling wrong");
    corr_addr_len_a: assert property (@(posedge clk) disable iff (!reset_n)
        valid_r && cmd_r.kind == opcode_decoder_pkg::OP_CORR_RD
        |-> cmd_r.addr_bytes == `ADDR_BYTES_4)
        else $error("correction read address length wrong");
    ddr_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
        valid_r && (cmd_r.kind == opcode_decoder_pkg::OP_DDR_RD ||
        cmd_r.kind == opcode_decoder_pkg::OP_DDR_TWO_IO ||
        cmd_r.kind == opcode_decoder_pkg::OP_DDR_FOUR_IO)
        |-> cmd_r.fmax_mhz == `FMAX_80)
        else $error("double rate ceiling wrong");
    multi_line_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
        valid_r && (cmd_r.kind == opcode_decoder_pkg::OP_TWO_OUT ||
        cmd_r.kind == opcode_decoder_pkg::OP_FOUR_IO)
        |-> cmd_r.fmax_mhz == `FMAX_104)
        else $error("multi-line ceiling wrong");
    var_addr_len_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_PLAIN_RD
        |=> valid_r && cmd_r.addr_bytes ==
            ($past(long_s2_r) ? `ADDR_BYTES_4 : `ADDR_BYTES_3))
        else $error("per-mode address length wrong");
    fixed_addr_len_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_PAGE4_32
        |=> valid_r && cmd_r.addr_bytes == `ADDR_BYTES_4)
        else $error("fixed address length wrong");
    unknown_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && !known_w |=> !valid_r && cmd_ignored_r)
        else $error("unknown opcode not ignored");
    bank_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_BANK_LEGACY
        |=> cmd_r.kind == opcode_decoder_pkg::OP_BANK_ACCESS)
        else $error("bank access not decoded");

    // identification and register opcodes
    maker_sig_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_MAKER_SIG
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_MAKER_SIG)
        else $error("maker signature not decoded");
    ident_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_IDENT
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_IDENT)
        else $error("identification read not decoded");
    params_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_PARAMS
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_PARAMS
            && cmd_r.fmax_mhz == `FMAX_133)
        else $error("parameter read not decoded");
    stat_cfg_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_STAT_CFG_WR
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_STAT_CFG_WR)
        else $error("status write not decoded");
    stat_clr_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_STAT_CLR
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_STAT_CLR)
        else $error("status clear not decoded");
    learn_rd_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_LEARN_RD
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_LEARN_RD)
        else $error("learning read not decoded");
    learn_nv_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_LEARN_NV
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_LEARN_NV)
        else $error("learning program not decoded");
    learn_vol_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_LEARN_VOL
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_LEARN_VOL)
        else $error("learning write not decoded");

    // array reads: kind, fixed lengths and ceilings
    plain_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_PLAIN_RD32
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_PLAIN_RD
            && cmd_r.addr_bytes == `ADDR_BYTES_4)
        else $error("plain read long form wrong");
    lat_read_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_LAT_RD
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_LAT_RD
            && cmd_r.fmax_mhz == `FMAX_133)
        else $error("latency read not decoded");
    lat_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_LAT_RD32
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_LAT_RD
            && cmd_r.addr_bytes == `ADDR_BYTES_4)
        else $error("latency read long form wrong");
    ddr_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_DDR_RD32
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_DDR_RD
            && cmd_r.addr_bytes == `ADDR_BYTES_4)
        else $error("double rate read long form wrong");
    four_out_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
        valid_r && cmd_r.kind == opcode_decoder_pkg::OP_FOUR_OUT
        |-> cmd_r.fmax_mhz == `FMAX_104)
        else $error("four-line output ceiling wrong");
    two_io_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
        valid_r && cmd_r.kind == opcode_decoder_pkg::OP_TWO_IO
        |-> cmd_r.fmax_mhz == `FMAX_104)
        else $error("two-line io ceiling wrong");
    four_io_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_FOUR_IO32
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_FOUR_IO
            && cmd_r.addr_bytes == `ADDR_BYTES_4)
        else $error("four-line io long form wrong");
    ddr_two_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_DDR_TWO_IO
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_DDR_TWO_IO
            && cmd_r.fmax_mhz == `FMAX_80)
        else $error("double rate two-line io wrong");
    ddr_four_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_DDR_FOUR_IO32
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_DDR_FOUR_IO
            && cmd_r.addr_bytes == `ADDR_BYTES_4)
        else $error("double rate four-line io wrong");

    // page writes
    page_single_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_PAGE
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_PAGE_SINGLE
            && cmd_r.fmax_mhz == `FMAX_133)
        else $error("single page write wrong");
    page_alt_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_PAGE4_ALT
        |=> valid_r && cmd_r.kind == opcode_decoder_pkg::OP_PAGE_FOUR
            && cmd_r.fmax_mhz == `FMAX_80)
        else $error("alternate four-line page write wrong");

    // address mode, pulse width and ignored opcodes
    long_mode_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && byte_s_r == `OP_TWO_OUT
        |=> valid_r && cmd_r.addr_bytes ==
            ($past(long_s2_r) ? `ADDR_BYTES_4 : `ADDR_BYTES_3))
        else $error("two-line output address length wrong");
    valid_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        valid_r |=> !valid_r)
        else $error("decode pulse longer than one cycle");
    unknown_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
        new_byte && !known_w |=> $stable(cmd_r))
        else $error("unknown opcode changed the result");

endmodule

/* test/spi_host_model.sv */
`timescale 1ns/1ps

// host side of the serial link: one frame per request, mode 0 timing
module spi_host_model (
    // request from the bench, core clock domain
    input wire logic clk,
    input wire logic req,
    input wire logic [15:0] op,
    input wire logic [4:0] nbits,
    // frame in progress
    output logic busy,
    // serial link towards the device
    output logic sck,
    output logic cs_n,
    output logic si
);
    int i;

    initial begin
        busy = 1'b0;
        sck = 1'b0;
        cs_n = 1'b0;
        si = 1'b1;
        // a deselect edge clears the link logic before the first frame
        #1 cs_n = 1'b1;
    end

    // the 32 ns link clock only runs inside a frame and its edges coincide with clk rising edges
    always begin
        @(posedge clk);
        if (req === 1'b1) begin
            #1;
            busy = 1'b1;
            cs_n = 1'b0;
            #7;
            for (i = 0; i < nbits; i++) begin
                si = op[15 - i]; // msb first
                #8 sck = 1'b1;
                #16 sck = 1'b0;
                #8;
            end
            // released line must not keep showing the last bit
            si = ~si;
            #8 cs_n = 1'b1;
            #8 busy = 1'b0;
        end
    end
endmodule

/* test/test_serial_flash_opcode_decoder.sv */
`timescale 1ns/1ps

module test_serial_flash_opcode_decoder;
    logic clk, reset_n, sck, cs_n, si, lng, req, busy;
    logic cmd_valid, cmd_ignored_r, failure_cleared_r;
    logic [15:0] opw;
    logic [4:0] nbw;
    opcode_decoder_pkg::decode_t cmd_r, seen;
    int errors, n_tests, n_valid, cyc;

    serial_flash_opcode_decoder dut_u (.clk(clk), .reset_n(reset_n),
        .sck(sck), .cs_n(cs_n), .si(si), .long_address_enable(lng),
        .cmd_valid(cmd_valid), .cmd_r(cmd_r), .cmd_ignored_r(cmd_ignored_r),
        .failure_cleared_r(failure_cleared_r));

    spi_host_model host_u (.clk(clk), .req(req), .op(opw), .nbits(nbw),
        .busy(busy), .sck(sck), .cs_n(cs_n), .si(si));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // count decode pulses and keep what each one carried
    always @(posedge clk) begin
        cyc++;
        if (cmd_valid === 1'b1) begin
            n_valid++;
            seen <= cmd_r;
        end
        if (cyc == 90000) begin
            errors++;
            results();
        end
    end

    task results;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one frame, then enough cycles for the synchroniser to settle
    task frame(input logic [15:0] op, input logic [4:0] nb);
        int i;
        @(posedge clk);
        req <= 1'b1;
        opw <= op;
        nbw <= nb;
        i = 0;
        while (busy !== 1'b1 && i < 50) begin
            @(posedge clk);
            i++;
        end
        req <= 1'b0;
        i = 0;
        while (busy !== 1'b0 && i < 500) begin
            @(posedge clk);
            i++;
        end
        repeat (10) @(posedge clk);
    endtask

    // expected decode of one instruction byte
    function automatic opcode_decoder_pkg::decode_t spec(
            input logic [7:0] op, input logic lg);
        opcode_decoder_pkg::decode_t d;
        d = '0;
        d.opcode = op;
        d.fmax_mhz = 8'h85;
        case (op)
            8'h90: d.kind = opcode_decoder_pkg::OP_MAKER_SIG;
            8'h9F: d.kind = opcode_decoder_pkg::OP_IDENT;
            8'hAB: d.kind = opcode_decoder_pkg::OP_LEGACY_SIG;
            8'h5A: d.kind = opcode_decoder_pkg::OP_PARAMS;
            8'h01: d.kind = opcode_decoder_pkg::OP_STAT_CFG_WR;
            8'h30: d.kind = opcode_decoder_pkg::OP_STAT_CLR;
            8'h04: d.kind = opcode_decoder_pkg::OP_WR_LATCH_CLR;
            8'h18: d.kind = opcode_decoder_pkg::OP_CORR_RD;
            8'hB9: d.kind = opcode_decoder_pkg::OP_BANK_ACCESS;
            8'h41: d.kind = opcode_decoder_pkg::OP_LEARN_RD;
            8'h43: d.kind = opcode_decoder_pkg::OP_LEARN_NV;
            8'h4A: d.kind = opcode_decoder_pkg::OP_LEARN_VOL;
            8'h03, 8'h13: d.kind = opcode_decoder_pkg::OP_PLAIN_RD;
            8'h0B, 8'h0C: d.kind = opcode_decoder_pkg::OP_LAT_RD;
            8'h0D, 8'h0E: d.kind = opcode_decoder_pkg::OP_DDR_RD;
            8'h3B, 8'h3C: d.kind = opcode_decoder_pkg::OP_TWO_OUT;
            8'h6B, 8'h6C: d.kind = opcode_decoder_pkg::OP_FOUR_OUT;
            8'hBB, 8'hBC: d.kind = opcode_decoder_pkg::OP_TWO_IO;
            8'hEB, 8'hEC: d.kind = opcode_decoder_pkg::OP_FOUR_IO;
            8'hBD, 8'hBE: d.kind = opcode_decoder_pkg::OP_DDR_TWO_IO;
            8'hED, 8'hEE: d.kind = opcode_decoder_pkg::OP_DDR_FOUR_IO;
            8'h02, 8'h12: d.kind = opcode_decoder_pkg::OP_PAGE_SINGLE;
            8'h32, 8'h38, 8'h34:
                d.kind = opcode_decoder_pkg::OP_PAGE_FOUR;
            default: d.kind = opcode_decoder_pkg::OP_NONE;
        endcase
        if (op inside {8'hAB, 8'h03, 8'h13})
            d.fmax_mhz = 8'h32;
        if (op inside {8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE, 8'h32,
                8'h38, 8'h34})
            d.fmax_mhz = 8'h50;
        if (op inside {8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB,
                8'hEC})
            d.fmax_mhz = 8'h68;
        if (d.kind >= opcode_decoder_pkg::OP_PLAIN_RD)
            d.addr_bytes = lg ? 3'h4 : 3'h3;
        if (op inside {8'h18, 8'h13, 8'h0C, 8'h0E, 8'h3C, 8'h6C, 8'hBC,
                8'hEC, 8'hBE, 8'hEE, 8'h12, 8'h34})
            d.addr_bytes = 3'h4;
        return d;
    endfunction

    // every byte value, with short and long addressing
    task t_all;
        opcode_decoder_pkg::decode_t e;
        int base;
        logic known;
        for (int l = 0; l < 2; l++) begin
            @(posedge clk);
            lng <= l[0];
            repeat (6) @(posedge clk);
            for (int k = 0; k < 256; k++) begin
                e = spec(k[7:0], l[0]);
                known = (e.kind !== opcode_decoder_pkg::OP_NONE);
                base = n_valid;
                frame({k[7:0], 8'h00}, 5'h08);
                chk(n_valid - base, {31'h0, known});
                chk({31'h0, cmd_ignored_r}, {31'h0, ~known});
                if (known)
                    chk({3'h0, seen}, {3'h0, e});
            end
        end
    endtask

    // short frames decode nothing, trailing bits never decode
    task t_frames;
        int base;
        base = n_valid;
        frame(16'h0300, 5'h05);
        chk(n_valid - base, 32'h0);
        frame(16'hFF03, 5'h10);
        chk(n_valid - base, 32'h0);
        frame(16'h9F03, 5'h10);
        chk(n_valid - base, 32'h1);
        chk({27'h0, seen.kind}, {27'h0, opcode_decoder_pkg::OP_IDENT});
    endtask

    // status clear then write latch clear, wrong order first, then reset
    task t_recover;
        frame(16'h0400, 5'h08);
        frame(16'h3000, 5'h08);
        chk({31'h0, failure_cleared_r}, 32'h0);
        frame(16'h0400, 5'h08);
        chk({31'h0, failure_cleared_r}, 32'h1);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk({1'h0, cmd_r, failure_cleared_r, cmd_ignored_r}, 32'h0);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    initial begin
        reset_n = 1'b0;
        lng = 1'b0;
        req = 1'b0;
        opw = 16'h0000;
        nbw = 5'h00;
        errors = 0;
        n_tests = 0;
        n_valid = 0;
        cyc = 0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_all();
        t_frames();
        t_recover();
        results();
    end
endmodule
